// File: exec_model.sv
`timescale 1ns/1ps
// ****************************************
// Execution units seen from the core
// ****************************************
module exec_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [5:0] disp_valid,
	input wire logic [5:0][6:0] disp_tag,
	input wire logic [5:0][2:0] disp_kind,
	input wire logic redirect_valid,
	input wire logic hold,
	input wire logic lifo,
	input wire logic exc_en,
	input wire logic misp_en,
	input wire logic [7:0] dly,
	input wire logic [31:0] target,
	input wire logic [31:0] data,
	output logic cmp_valid,
	output logic [6:0] cmp_tag,
	output logic [31:0] cmp_data,
	output logic cmp_exc,
	output logic cmp_misp,
	output logic [31:0] cmp_target
);
	logic [9:0] q[$];
	logic [9:0] e;
	logic [7:0] gap;
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q.delete();
			gap = 8'h00;
			cmp_valid <= 1'b0;
			cmp_tag <= 7'h00;
			cmp_data <= 32'h0000_0000;
			cmp_exc <= 1'b0;
			cmp_misp <= 1'b0;
			cmp_target <= 32'h0000_0000;
		end else begin
			// Idle qualifiers wander so a stale value is never trusted
			cmp_valid <= 1'b0;
			cmp_tag <= ~cmp_tag;
			cmp_data <= ~cmp_data;
			cmp_exc <= ~cmp_exc;
			cmp_misp <= ~cmp_misp;
			cmp_target <= ~cmp_target;
			if (redirect_valid) begin
				q.delete(); // Queued tags are dropped; a tag popped on the edge that raised the redirect still completes
			end else begin
				for (int i = 0; i < 6; i++) begin
					if (disp_valid[i]) begin
						q.push_back({disp_kind[i], disp_tag[i]});
					end
				end
				if (gap != 8'h00) begin
					gap = gap - 8'h01;
				end else if (!hold && q.size() != 0) begin
					e = lifo ? q.pop_back() : q.pop_front();
					gap = dly;
					// At most one completion per cycle
					cmp_valid <= 1'b1;
					cmp_tag <= e[6:0];
					cmp_data <= data;
					cmp_exc <= exc_en && e[9:7] == ooo_types_pkg::kind_fp;
					cmp_misp <= misp_en && e[9:7] == ooo_types_pkg::kind_branch;
					cmp_target <= target;
				end
			end
		end
	end
endmodule : exec_model

// File: ooo_core_ctrl.sv
`timescale 1ns/1ps
`include "ooo_params.svh"
module ooo_core_ctrl #(
	parameter int AW = 32,
	parameter int DW = 32,
	parameter int QD = `Q_DEPTH,
	parameter int ND = `DISP_MAX,
	parameter int NR = `RET_MAX,
	parameter int BTT_N = `BTT_ENTRIES,
	parameter int TS = `TRACE_SLOTS,
	parameter int FD = `FE_FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic fe_valid,
	output logic fe_ready,
	input wire logic [2:0] fe_kind,
	input wire logic [3:0] fe_dest,
	input wire logic fe_wr,
	input wire logic [AW-1:0] fe_pc,
	output logic [ND-1:0] disp_valid,
	output logic [ND-1:0][$clog2(QD)-1:0] disp_tag,
	output logic [ND-1:0][2:0] disp_kind,
	input wire logic cmp_valid,
	input wire logic [$clog2(QD)-1:0] cmp_tag,
	input wire logic [DW-1:0] cmp_data,
	input wire logic cmp_exc,
	input wire logic cmp_misp,
	input wire logic [AW-1:0] cmp_target,
	output logic [NR-1:0] ret_valid,
	output logic [NR-1:0] store_commit,
	input wire logic [3:0] arch_rd_idx,
	output logic [DW-1:0] arch_rd_data,
	output logic exc_valid,
	output logic [AW-1:0] exc_pc,
	output logic redirect_valid,
	output logic [AW-1:0] redirect_addr,
	input wire logic bp_req,
	input wire logic [AW-1:0] bp_addr,
	output logic bp_hit,
	output logic [AW-1:0] bp_target,
	input wire logic br_next_valid,
	input wire logic [AW-1:0] br_next_addr,
	input wire logic trace_wr,
	input wire logic [AW-1:0] trace_start,
	output logic fetch_stop,
	output logic [$clog2(TS)-1:0] trace_slot
);
	localparam int QIW = $clog2(QD);
	localparam int BW = $clog2(BTT_N);
	localparam int TW = $clog2(TS);
	localparam int FW = 3 + 4 + 1 + AW;
	typedef ooo_types_pkg::uop_kind_type kind_type;

	// ****************************************
	// Commit queue storage
	// ****************************************
	logic [QD-1:0] done_r, disp_r, exc_r, misp_r, wr_r;
	kind_type kind_r [QD];
	logic [3:0] dest_r [QD];
	logic [AW-1:0] pc_r [QD];
	logic [AW-1:0] tgt_r [QD];
	logic [DW-1:0] res_r [QD];
	logic [QIW-1:0] head_r, tail_r;
	logic [QIW:0] cnt_r;
	logic [QIW:0] ld_cnt_r, st_cnt_r;
	logic [DW-1:0] arch_r [`ARCH_REGS];
	ooo_types_pkg::core_state_type state_r;

	function automatic logic [QIW-1:0] qadd(input logic [QIW-1:0] a,
		input int b);
		int s;
		s = int'(a) + b;
		if (s >= QD) begin
			s = s - QD;
		end
		return s[QIW-1:0];
	endfunction : qadd

	// ****************************************
	// Front-end buffer and allocation
	// ****************************************
	logic q_valid, q_ready, alloc, flush;
	logic [FW-1:0] q_data;
	kind_type q_kind;

	uop_fifo #(.W(FW), .D(FD)) u_fe_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.flush(flush),
		.in_valid(fe_valid),
		.in_ready(fe_ready),
		.in_data({fe_kind, fe_dest, fe_wr, fe_pc}),
		.out_valid(q_valid),
		.out_ready(q_ready),
		.out_data(q_data)
	);

	assign q_kind = kind_type'(q_data[FW-1 -: 3]);
	// Loads and stores stall at the head of the FIFO when ordering slots run out
	assign q_ready = state_r == ooo_types_pkg::st_run && !flush &&
		cnt_r < (QIW+1)'(QD) &&
		!(q_kind == ooo_types_pkg::kind_load &&
		ld_cnt_r >= (QIW+1)'(`LOAD_MAX)) &&
		!(q_kind == ooo_types_pkg::kind_store &&
		st_cnt_r >= (QIW+1)'(`STORE_MAX));
	assign alloc = q_valid && q_ready;

	// ****************************************
	// Retire selection
	// ****************************************
	logic [NR-1:0] ret_mask;
	logic [NR-1:0][QIW-1:0] ret_idx;
	logic [1:0] ret_n;
	logic [QIW:0] ret_ld, ret_st;
	logic take_exc, take_misp, rstop;
	logic [QIW-1:0] misp_idx;

	always_comb begin
		ret_mask = '0;
		ret_idx = '0;
		ret_n = '0;
		ret_ld = '0;
		ret_st = '0;
		take_exc = 1'b0;
		take_misp = 1'b0;
		rstop = 1'b0;
		misp_idx = '0;
		for (int k = 0; k < NR; k++) begin
			ret_idx[k] = qadd(head_r, k);
			// Oldest first; a gap stops the group so order is never broken
			if (!rstop && k < int'(cnt_r) && done_r[ret_idx[k]]) begin
				if (exc_r[ret_idx[k]]) begin
					take_exc = (k == 0);
					rstop = 1'b1;
				end else begin
					ret_mask[k] = 1'b1;
					ret_n = ret_n + 2'd1;
					if (kind_r[ret_idx[k]] == ooo_types_pkg::kind_load) begin
						ret_ld = ret_ld + 1'b1;
					end
					if (kind_r[ret_idx[k]] == ooo_types_pkg::kind_store) begin
						ret_st = ret_st + 1'b1;
					end
					if (kind_r[ret_idx[k]] == ooo_types_pkg::kind_branch &&
						misp_r[ret_idx[k]]) begin
						take_misp = 1'b1;
						misp_idx = ret_idx[k];
						rstop = 1'b1;
					end
				end
			end else begin
				rstop = 1'b1;
			end
		end
	end

	assign flush = take_exc || take_misp;

	// ****************************************
	// Dispatch selection
	// ****************************************
	logic [ND-1:0] d_vec;
	logic [ND-1:0][QIW-1:0] d_tag;
	logic [ND-1:0][2:0] d_kind;
	logic [QIW-1:0] didx;
	logic d_fp, d_ok;
	int dn, alu_n;
	logic [1:0] fp_wait_r;
	logic disp_fp_r;
	logic [2:0] disp_alu_n_r;

	always_comb begin
		d_vec = '0;
		d_tag = '0;
		d_kind = '0;
		didx = '0;
		d_fp = 1'b0;
		d_ok = 1'b0;
		dn = 0;
		alu_n = 0;
		for (int i = 0; i < QD; i++) begin
			didx = qadd(head_r, i);
			if (!flush && i < int'(cnt_r) && !disp_r[didx] && dn < ND) begin
				d_ok = 1'b1;
				if (kind_r[didx] == ooo_types_pkg::kind_alu &&
					alu_n >= `ALU_PER_CYCLE) begin
					d_ok = 1'b0;
				end
				if (kind_r[didx] == ooo_types_pkg::kind_fp &&
					(fp_wait_r != '0 || d_fp)) begin
					d_ok = 1'b0;
				end
				if (d_ok) begin
					d_vec[dn] = 1'b1;
					d_tag[dn] = didx;
					d_kind[dn] = kind_r[didx];
					dn = dn + 1;
					if (kind_r[didx] == ooo_types_pkg::kind_alu) begin
						alu_n = alu_n + 1;
					end
					if (kind_r[didx] == ooo_types_pkg::kind_fp) begin
						d_fp = 1'b1;
					end
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			disp_valid <= '0;
			disp_tag <= '0;
			disp_kind <= '0;
			fp_wait_r <= '0;
			disp_fp_r <= 1'b0;
			disp_alu_n_r <= '0;
		end else if (ce) begin
			disp_valid <= d_vec;
			disp_tag <= d_tag;
			disp_kind <= d_kind;
			disp_fp_r <= d_fp;
			disp_alu_n_r <= alu_n[2:0];
			if (d_fp) begin
				fp_wait_r <= 2'(`FP_ISSUE_GAP - 1);
			end else if (fp_wait_r != '0) begin
				fp_wait_r <= fp_wait_r - 2'd1;
			end
		end
	end

	// ****************************************
	// Queue pointers and state
	// ****************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			head_r <= '0;
			tail_r <= '0;
			cnt_r <= '0;
			ld_cnt_r <= '0;
			st_cnt_r <= '0;
			state_r <= ooo_types_pkg::st_run;
		end else if (ce) begin
			head_r <= qadd(head_r, int'(ret_n));
			state_r <= ooo_types_pkg::st_run;
			if (flush) begin
				// Everything younger than the flush point is discarded
				tail_r <= qadd(head_r, int'(ret_n));
				cnt_r <= '0;
				ld_cnt_r <= '0;
				st_cnt_r <= '0;
				state_r <= ooo_types_pkg::st_redirect;
			end else begin
				if (alloc) begin
					tail_r <= qadd(tail_r, 1);
				end
				cnt_r <= cnt_r + (QIW+1)'(alloc) - (QIW+1)'(ret_n);
				ld_cnt_r <= ld_cnt_r - ret_ld + (QIW+1)'(alloc &&
					q_kind == ooo_types_pkg::kind_load);
				st_cnt_r <= st_cnt_r - ret_st + (QIW+1)'(alloc &&
					q_kind == ooo_types_pkg::kind_store);
			end
		end
	end

	// ****************************************
	// Entry fields and speculative results
	// ****************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			done_r <= '0;
			disp_r <= '0;
			exc_r <= '0;
			misp_r <= '0;
		end else if (ce) begin
			for (int j = 0; j < ND; j++) begin
				if (d_vec[j]) begin
					disp_r[d_tag[j]] <= 1'b1;
				end
			end
			if (cmp_valid) begin
				done_r[cmp_tag] <= 1'b1;
				exc_r[cmp_tag] <= cmp_exc;
				misp_r[cmp_tag] <= cmp_misp;
			end
			if (alloc) begin
				done_r[tail_r] <= 1'b0;
				disp_r[tail_r] <= 1'b0;
				exc_r[tail_r] <= 1'b0;
				misp_r[tail_r] <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (ce && alloc) begin
			kind_r[tail_r] <= q_kind;
			dest_r[tail_r] <= q_data[AW+4:AW+1];
			wr_r[tail_r] <= q_data[AW];
			pc_r[tail_r] <= q_data[AW-1:0];
		end
		if (ce && cmp_valid) begin
			res_r[cmp_tag] <= cmp_data;
			tgt_r[cmp_tag] <= cmp_target;
		end
	end

	// ****************************************
	// Architectural commit
	// ****************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int r = 0; r < `ARCH_REGS; r++) begin
				arch_r[r] <= '0;
			end
			ret_valid <= '0;
			store_commit <= '0;
			arch_rd_data <= '0;
		end else if (ce) begin
			ret_valid <= ret_mask;
			arch_rd_data <= arch_r[arch_rd_idx];
			for (int k = 0; k < NR; k++) begin
				store_commit[k] <= ret_mask[k] &&
					kind_r[ret_idx[k]] == ooo_types_pkg::kind_store;
				// Later slots win, which matches program order
				if (ret_mask[k] && wr_r[ret_idx[k]]) begin
					arch_r[dest_r[ret_idx[k]]] <= res_r[ret_idx[k]];
				end
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			exc_valid <= 1'b0;
			exc_pc <= '0;
			redirect_valid <= 1'b0;
			redirect_addr <= '0;
		end else if (ce) begin
			exc_valid <= take_exc;
			redirect_valid <= flush;
			if (take_exc) begin
				exc_pc <= pc_r[head_r];
				redirect_addr <= AW'(`EXC_VECTOR);
			end else if (take_misp) begin
				redirect_addr <= tgt_r[misp_idx];
			end
		end
	end

	// ****************************************
	// Branch target table and traces
	// ****************************************
	logic [BTT_N-1:0] btt_v_r;
	logic [AW-1:0] btt_tgt_r [BTT_N];
	logic [TS-1:0] trace_v_r;
	logic [AW-1:0] trace_start_r [TS];
	logic [TW-1:0] trace_wp_r;
	logic trace_hit;
	logic [TW-1:0] hit_slot;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			btt_v_r <= '0;
			bp_hit <= 1'b0;
			bp_target <= '0;
		end else if (ce) begin
			bp_hit <= bp_req && btt_v_r[bp_addr[BW-1:0]];
			bp_target <= btt_tgt_r[bp_addr[BW-1:0]];
			for (int k = 0; k < NR; k++) begin
				if (ret_mask[k] &&
					kind_r[ret_idx[k]] == ooo_types_pkg::kind_branch) begin
					btt_v_r[pc_r[ret_idx[k]][BW-1:0]] <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		for (int k = 0; k < NR; k++) begin
			if (ce && ret_mask[k] &&
				kind_r[ret_idx[k]] == ooo_types_pkg::kind_branch) begin
				btt_tgt_r[pc_r[ret_idx[k]][BW-1:0]] <= tgt_r[ret_idx[k]];
			end
		end
	end

	always_comb begin
		trace_hit = 1'b0;
		hit_slot = '0;
		for (int t = TS - 1; t >= 0; t--) begin
			if (trace_v_r[t] && trace_start_r[t] == br_next_addr) begin
				trace_hit = 1'b1;
				hit_slot = TW'(t);
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			trace_v_r <= '0;
			trace_wp_r <= '0;
			fetch_stop <= 1'b0;
			trace_slot <= '0;
			for (int t = 0; t < TS; t++) begin
				trace_start_r[t] <= '0;
			end
		end else if (ce) begin
			fetch_stop <= br_next_valid && trace_hit;
			trace_slot <= hit_slot;
			// A changed target makes the trace built for the old one useless
			for (int k = 0; k < NR; k++) begin
				for (int t = 0; t < TS; t++) begin
					if (ret_mask[k] &&
						kind_r[ret_idx[k]] == ooo_types_pkg::kind_branch &&
						btt_v_r[pc_r[ret_idx[k]][BW-1:0]] &&
						btt_tgt_r[pc_r[ret_idx[k]][BW-1:0]] != tgt_r[ret_idx[k]] &&
						trace_start_r[t] ==
						btt_tgt_r[pc_r[ret_idx[k]][BW-1:0]]) begin
						trace_v_r[t] <= 1'b0;
					end
				end
			end
			if (trace_wr) begin
				trace_v_r[trace_wp_r] <= 1'b1;
				trace_start_r[trace_wp_r] <= trace_start;
				trace_wp_r <= trace_wp_r + 1'b1;
			end
		end
	end

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_misp_retire;
		ce && take_misp;
	endsequence
	sequence s_flushed;
		cnt_r == '0 && redirect_valid && ret_valid != '0;
	endsequence
	property p_misp_flush;
		s_misp_retire |=> s_flushed;
	endproperty
	a_misp_flush: assert property (p_misp_flush)
		else $error("younger work kept after mispredict");
	property p_exc_late;
		ce && take_exc |=> exc_valid && ret_valid == '0 && cnt_r == '0;
	endproperty
	a_exc_late: assert property (p_exc_late)
		else $error("exception not taken alone at retire");
	property p_disp_pack;
		(disp_valid & (disp_valid + 1'b1)) == '0;
	endproperty
	a_disp_pack: assert property (p_disp_pack)
		else $error("dispatch slots not packed");
	property p_alu_rate;
		disp_alu_n_r <= 3'(`ALU_PER_CYCLE);
	endproperty
	a_alu_rate: assert property (p_alu_rate)
		else $error("too many ALU ops dispatched");
	property p_fp_gap;
		ce && disp_fp_r |=> !disp_fp_r;
	endproperty
	a_fp_gap: assert property (p_fp_gap)
		else $error("FP ops dispatched back to back");
	property p_cap;
		cnt_r <= (QIW+1)'(QD);
	endproperty
	a_cap: assert property (p_cap)
		else $error("queue over capacity");
	property p_ldst;
		ld_cnt_r <= (QIW+1)'(`LOAD_MAX) && st_cnt_r <= (QIW+1)'(`STORE_MAX);
	endproperty
	a_ldst: assert property (p_ldst)
		else $error("load or store limit exceeded");
	property p_ret_order;
		ce && ret_mask != '0 |-> done_r[head_r] && !exc_r[head_r]
			##1 (ret_valid & (ret_valid + 1'b1)) == '0;
	endproperty
	a_ret_order: assert property (p_ret_order)
		else $error("retire out of order or not done");
	property p_trace;
		ce && br_next_valid && trace_hit |=> fetch_stop;
	endproperty
	a_trace: assert property (p_trace)
		else $error("trace hit did not stop fetch");
endmodule : ooo_core_ctrl

// File: ooo_params.svh
`ifndef OOO_PARAMS_SVH
`define OOO_PARAMS_SVH
`define Q_DEPTH 126
`define DISP_MAX 6
`define ALU_PER_CYCLE 2
`define FP_ISSUE_GAP 2
`define RET_MAX 3
`define LOAD_MAX 48
`define STORE_MAX 24
`define BTT_ENTRIES 4096
`define ARCH_REGS 16
`define TRACE_SLOTS 4
`define FE_FIFO_DEPTH 8
`define EXC_VECTOR 32'h0000_1000
`endif

// File: ooo_types_pkg.sv
package ooo_types_pkg;
	typedef enum logic [2:0] {
		kind_alu = 3'b000,
		kind_fp = 3'b001,
		kind_load = 3'b010,
		kind_store = 3'b011,
		kind_branch = 3'b100
	} uop_kind_type;
	typedef enum logic [1:0] {
		st_run = 2'b00,
		st_redirect = 2'b01
	} core_state_type;
endpackage : ooo_types_pkg

// File: tb_top.sv
`timescale 1ns/1ps
`include "ooo_params.svh"
// ****************************************
// Core control testbench
// ****************************************
module tb_top;
	logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, fe_valid = 1'b0, fe_ready;
	logic [2:0] fe_kind = 3'h0;
	logic [3:0] fe_dest = 4'h0, arch_rd_idx = 4'h0;
	logic fe_wr = 1'b0, cmp_valid, cmp_exc, cmp_misp, exc_valid;
	logic [31:0] fe_pc = 32'h0000_0000, cmp_data, cmp_target, exc_pc;
	logic [5:0] disp_valid;
	logic [5:0][6:0] disp_tag;
	logic [5:0][2:0] disp_kind;
	logic [6:0] cmp_tag;
	logic [2:0] ret_valid, store_commit;
	logic [31:0] arch_rd_data, redirect_addr, bp_target;
	logic redirect_valid, bp_hit, fetch_stop, bp_req = 1'b0;
	logic br_next_valid = 1'b0, trace_wr = 1'b0;
	logic [31:0] bp_addr = 32'h0000_0000, br_next_addr = 32'h0000_0000;
	logic [31:0] trace_start = 32'h0000_0000;
	logic [1:0] trace_slot;
	logic hold = 1'b0, lifo = 1'b0, exc_en = 1'b0, misp_en = 1'b0;
	logic [7:0] dly = 8'h00;
	logic [31:0] target = 32'h0000_0000, data = 32'h0000_0000;
	logic [31:0] ev_addr, ev_pc;
	int n_mismatch = 0, n_tests = 0, n_ret = 0, n_st = 0, cyc = 0, ev_n = 0;
	int na, nf, fp_prev = 0;
	bit acc;
	always #4 clk = ~clk;
	ooo_core_ctrl dut (.clk, .rst_n, .ce, .fe_valid, .fe_ready, .fe_kind,
		.fe_dest, .fe_wr, .fe_pc, .disp_valid, .disp_tag, .disp_kind,
		.cmp_valid, .cmp_tag, .cmp_data, .cmp_exc, .cmp_misp, .cmp_target,
		.ret_valid, .store_commit, .arch_rd_idx, .arch_rd_data, .exc_valid,
		.exc_pc, .redirect_valid, .redirect_addr, .bp_req, .bp_addr, .bp_hit,
		.bp_target, .br_next_valid, .br_next_addr, .trace_wr, .trace_start,
		.fetch_stop, .trace_slot);
	exec_model xu (.clk, .rst_n, .disp_valid, .disp_tag, .disp_kind,
		.redirect_valid, .hold, .lifo, .exc_en, .misp_en, .dly, .target,
		.data, .cmp_valid, .cmp_tag, .cmp_data, .cmp_exc, .cmp_misp,
		.cmp_target);
	task automatic check(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic end_of_test();
		$display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : end_of_test
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			n_mismatch++;
			end_of_test();
		end
	end
	// Settled outputs are watched mid-cycle
	always @(negedge clk) begin
		if (rst_n) begin
			na = 0;
			nf = 0;
			for (int i = 0; i < 6; i++) begin
				na += disp_valid[i] && disp_kind[i] == ooo_types_pkg::kind_alu;
				nf += disp_valid[i] && disp_kind[i] == ooo_types_pkg::kind_fp;
			end
			if (|disp_valid) check("alu per cycle", na <= 2, 1);
			if (nf != 0) check("fp spacing", fp_prev, 0);
			fp_prev = nf;
			n_ret += $countones(ret_valid);
			n_st += $countones(store_commit);
			if (|ret_valid) check("retire group", ret_valid inside
				{3'b001, 3'b011, 3'b111}, 1);
			if (redirect_valid === 1'b1) begin
				ev_n++;
				ev_addr = redirect_addr;
			end
			if (exc_valid === 1'b1) ev_pc = exc_pc;
		end
	end
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step
	task automatic push(input logic [2:0] k, input logic [3:0] d,
		input logic w, input logic [31:0] pc, input int lim);
		acc = 1'b0;
		fe_valid = 1'b1;
		fe_kind = k;
		fe_dest = d;
		fe_wr = w;
		fe_pc = pc;
		for (int i = 0; i < lim && !acc; i++) begin
			#6 acc = fe_ready === 1'b1;
			step(1);
		end
		fe_valid = 1'b0;
		fe_pc = ~pc;
		// Let an edge pass so a following push never re-drives valid at once
		step(1);
	endtask : push
	task automatic drain(input int base, input int exp);
		for (int i = 0; i < 2000 && n_ret - base < exp; i++) step(1);
		step(5);
		check("retired", n_ret - base, exp);
	endtask : drain
	task automatic s_stream();
		int b = n_ret;
		lifo = 1'b1;
		for (int i = 0; i < 12; i++) begin
			push(ooo_types_pkg::kind_alu, 4'h0, 1'b0, 32'h0000_0100, 40);
		end
		drain(b, 12);
		b = n_ret;
		for (int i = 0; i < 6; i++) begin
			push(ooo_types_pkg::kind_fp, 4'h8, 1'b0, 32'h0000_0110, 40);
		end
		drain(b, 6);
		lifo = 1'b0;
	endtask : s_stream
	task automatic s_limits();
		logic [2:0] kd[3] = '{ooo_types_pkg::kind_alu,
			ooo_types_pkg::kind_load, ooo_types_pkg::kind_store};
		int cap[3] = '{`Q_DEPTH, `LOAD_MAX, `STORE_MAX};
		int b, s, n;
		for (int k = 0; k < 3; k++) begin
			b = n_ret;
			s = n_st;
			n = 0;
			hold = 1'b1;
			acc = 1'b1;
			while (acc && n < 300) begin
				push(kd[k], 4'h0, 1'b0, 32'h0000_0200, 4);
				n += acc;
			end
			check("accepted", n, cap[k] + `FE_FIFO_DEPTH);
			hold = 1'b0;
			drain(b, n);
			if (k == 2) check("stores", n_st - s, n);
		end
	endtask : s_limits
	task automatic s_arch();
		int b = n_ret;
		lifo = 1'b1;
		dly = 8'h14;
		data = 32'hA5A5_0001;
		hold = 1'b1;
		push(ooo_types_pkg::kind_alu, 4'h1, 1'b0, 32'h0000_0300, 40);
		push(ooo_types_pkg::kind_alu, 4'h5, 1'b1, 32'h0000_0304, 40);
		step(4);
		hold = 1'b0;
		arch_rd_idx = 4'h5;
		step(12);
		check("spec reg", arch_rd_data, 32'h0000_0000);
		check("early retire", n_ret - b, 0);
		drain(b, 2);
		check("arch reg", arch_rd_data, 32'hA5A5_0001);
		lifo = 1'b0;
		dly = 8'h00;
	endtask : s_arch
	task automatic s_exc();
		int b = n_ret;
		int c = ev_n;
		exc_en = 1'b1;
		push(ooo_types_pkg::kind_alu, 4'h0, 1'b0, 32'h0000_0100, 40);
		push(ooo_types_pkg::kind_fp, 4'h9, 1'b0, 32'h0000_0104, 40);
		push(ooo_types_pkg::kind_alu, 4'h0, 1'b0, 32'h0000_0108, 40);
		for (int i = 0; i < 200 && ev_n == c; i++) step(1);
		step(20);
		check("exc pc", ev_pc, 32'h0000_0104);
		check("exc vector", ev_addr, `EXC_VECTOR);
		check("exc retired", n_ret - b, 1);
		exc_en = 1'b0;
	endtask : s_exc
	task automatic branch(input logic [31:0] t);
		int b = n_ret;
		int c = ev_n;
		misp_en = 1'b1;
		target = t;
		arch_rd_idx = 4'h2;
		push(ooo_types_pkg::kind_branch, 4'h0, 1'b0, 32'h0000_0200, 40);
		push(ooo_types_pkg::kind_alu, 4'h2, 1'b1, 32'h0000_0204, 40);
		for (int i = 0; i < 200 && ev_n == c; i++) step(1);
		step(20);
		check("redirect", ev_addr, t);
		check("misp retired", n_ret - b, 1);
		check("flushed reg", arch_rd_data, 32'h0000_0000);
		misp_en = 1'b0;
	endtask : branch
	task automatic lookup(input logic [31:0] a, input logic [31:0] t);
		bp_req = 1'b1;
		bp_addr = a;
		step(1);
		bp_req = 1'b0;
		bp_addr = ~a;
		check("bp hit", bp_hit, 1);
		check("bp target", bp_target, t);
	endtask : lookup
	task automatic probe(input logic [31:0] a, input logic hit);
		br_next_valid = 1'b1;
		br_next_addr = a;
		step(1);
		br_next_valid = 1'b0;
		br_next_addr = ~a;
		check("fetch stop", fetch_stop, hit);
		if (hit) check("trace slot", trace_slot, 2'h0);
		step(1);
	endtask : probe
	task automatic s_btt();
		branch(32'h0000_2000);
		lookup(32'h0000_0200, 32'h0000_2000);
		trace_wr = 1'b1;
		trace_start = 32'h0000_2000;
		step(1);
		trace_wr = 1'b0;
		trace_start = 32'hFFFF_DFFF;
		probe(32'h0000_2000, 1'b1);
		probe(32'h0000_3000, 1'b0);
		branch(32'h0000_4000);
		lookup(32'h0000_0200, 32'h0000_4000);
		probe(32'h0000_2000, 1'b0);
		// A lookup made while the enable is low must leave the answer frozen
		ce = 1'b0;
		bp_req = 1'b1;
		bp_addr = 32'h0000_0200;
		step(2);
		check("frozen hit", bp_hit, 0);
		ce = 1'b1;
		step(1);
		check("thawed hit", bp_hit, 1);
		bp_req = 1'b0;
	endtask : s_btt
	initial begin
		step(4);
		rst_n = 1'b1;
		s_stream();
		s_limits();
		s_arch();
		s_exc();
		s_btt();
		end_of_test();
	end
endmodule : tb_top

// File: uop_fifo.sv
`timescale 1ns/1ps
module uop_fifo #(
	parameter int W = 8,
	parameter int D = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int PW = (D > 1) ? $clog2(D) : 1;
	logic [W-1:0] mem_r [D];
	logic [PW-1:0] wp_r;
	logic [PW-1:0] rp_r;
	logic [PW:0] cnt_r;
	logic push;
	logic pop;

	assign in_ready = cnt_r != (PW+1)'(D);
	assign out_valid = cnt_r != '0;
	assign out_data = mem_r[rp_r];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge clk) begin
		if (ce && push && !flush) begin
			mem_r[wp_r] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_r <= '0;
			rp_r <= '0;
			cnt_r <= '0;
		end else if (ce) begin
			if (flush) begin
				wp_r <= '0;
				rp_r <= '0;
				cnt_r <= '0;
			end else begin
				if (push) begin
					wp_r <= (wp_r == PW'(D-1)) ? '0 : wp_r + 1'b1;
				end
				if (pop) begin
					rp_r <= (rp_r == PW'(D-1)) ? '0 : rp_r + 1'b1;
				end
				cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
			end
		end
	end
endmodule : uop_fifo
